// >>> shared/pob_pkg.sv
// Constants shared by the PHY option and receive pointer register bank.
// Assumes a 200 MHz APB clock and byte addresses on a 16-bit paddr.
package pob_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned STRB_W = 4;

   // ----------------------------------------------------------------
   // Register byte addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] OFF_PHY_OPT = 16'h0F10;
   localparam logic [15:0] OFF_RX_HEAD = 16'h2410;
   localparam logic [15:0] OFF_RX_TAIL = 16'h2418;
   localparam logic [15:0] OFF_RX_HEAD_ALIAS = 16'h8000;
   localparam logic [15:0] OFF_RX_TAIL_ALIAS = 16'h8008;

   // ----------------------------------------------------------------
   // PHY option register fields
   // ----------------------------------------------------------------
   localparam int unsigned OPT_W = 10;
   localparam int unsigned BIT_SLOW_ALWAYS = 1;
   localparam int unsigned BIT_SLOW_LOW_POWER = 2;
   localparam int unsigned BIT_GIG_BLOCK_LOW_POWER = 3;
   localparam int unsigned BIT_LINE_DRIVER_CLASS = 4;
   localparam int unsigned BIT_REAUTONEG = 5;
   localparam int unsigned BIT_GIG_DISABLE_ALL = 6;
   localparam int unsigned BIT_FLASH_UPD_BLOCK = 7;
   localparam int unsigned BIT_PAUSE = 8;
   localparam int unsigned BIT_ASYM_PAUSE = 9;
   localparam logic [9:0] OPT_RESET = 10'h30D;
   localparam int unsigned NVM_LOAD_W = 8;
   localparam int unsigned NVM_FIELD_LSB = 8;

   // ----------------------------------------------------------------
   // Receive pointer fields
   // ----------------------------------------------------------------
   localparam int unsigned PTR_W = 13;
   localparam logic [12:0] PTR_RESET = 13'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned RENEG_SETTLE_NS = 80;
   localparam int unsigned RENEG_SETTLE_CYC =
      (RENEG_SETTLE_NS * CLK_MHZ + 999) / 1000;

endpackage

// >>> hw/pob_ptr.sv
// One receive buffer pointer counted in 64-bit words.
// Assumes advance and write pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pob_ptr (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Hardware advance.
   input wire logic adv,
   // Software write with byte-lane mask.
   input wire logic wr_en,
   input wire logic [pob_pkg::PTR_W-1:0] wr_data,
   input wire logic [pob_pkg::PTR_W-1:0] wr_mask,
   // Pointer value.
   output logic [pob_pkg::PTR_W-1:0] ptr_q
);
   import pob_pkg::*;

   logic [PTR_W-1:0] ptr_d;
   logic [PTR_W-1:0] ptr_merged;

   // A software write replaces the bits set in wr_mask and keeps the rest; it beats a same-cycle step.
   assign ptr_merged = (ptr_q & ~wr_mask) | (wr_data & wr_mask);
   assign ptr_d = wr_en ? ptr_merged :
                  adv ? ptr_q + PTR_W'(1) : ptr_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= PTR_RESET;
      end else begin
         ptr_q <= ptr_d;
      end
   end

   a_ptr_advance: assert property (
      @(posedge clk) disable iff (!rst_n)
      adv && !wr_en |=> ptr_q == $past(ptr_q) + PTR_W'(1))
      else $error("Pointer did not advance by one word.");

   a_ptr_overwrite: assert property (
      @(posedge clk) disable iff (!rst_n)
      wr_en |=> ptr_q == $past(ptr_merged))
      else $error("Software write did not replace the pointer.");

endmodule
`default_nettype wire

// >>> hw/pob_regs.sv
// PHY option register and receive FIFO pointer registers on APB.
// Assumes nvm, power-state, flash and receive strobes share pclk.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Slow-link-always bit forces slowest link everywhere
// - Low-power slow bit applies outside fully active
// - Gig block bit applies outside fully active
// - Gig disable bit blocks 1000 everywhere
// - Writing bit five restarts auto-negotiation
// - Bit seven suppresses flash update on write
// - Bit eight drives pause advertisement, resets one
// - Bit nine drives asymmetric pause, resets one
// - NVM high byte loads option bits 7:0
// - Head pointer is 13 bits of words
// - Tail pointer is 13 bits of words
// - Pointers count from packet buffer start
// - Head alias address reaches head register
// - Tail alias address reaches tail register
// - Pointer upper bits read zero
module pob_regs (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pob_pkg::ADDR_W-1:0] paddr,
   input wire logic [pob_pkg::DATA_W-1:0] pwdata,
   input wire logic [pob_pkg::STRB_W-1:0] pstrb,
   output logic [pob_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Initialization word from non-volatile memory.
   input wire logic nvm_load,
   input wire logic [15:0] nvm_word,
   // Power state and flash control.
   input wire logic fully_active_state,
   input wire logic flash_read_control_wr,
   output logic flash_update_req,
   // PHY controls.
   output logic phy_slow_link,
   output logic phy_gig_disable,
   output logic phy_restart_an,
   output logic phy_line_driver_class,
   output logic phy_pause_adv,
   output logic phy_asym_pause_adv,
   // Receive packet buffer pointers.
   input wire logic rx_head_advance,
   input wire logic rx_tail_advance,
   output logic [pob_pkg::PTR_W-1:0] rx_head_pointer,
   output logic [pob_pkg::PTR_W-1:0] rx_tail_pointer
);
   import pob_pkg::*;

   // ----------------------------------------------------------------
   // Transfer phases and address decode
   // ----------------------------------------------------------------
   logic acc_first;
   logic acc_done;
   logic wr_fire;
   logic hit_opt;
   logic hit_head;
   logic hit_tail;
   logic hit_any;
   logic [15:0] lane_mask;

   // The first access cycle captures read data, the second completes.
   assign acc_first = psel & penable & ~pready;
   assign acc_done = psel & penable & pready;
   assign wr_fire = acc_done & pwrite & hit_any;
   assign hit_opt = (paddr == OFF_PHY_OPT);
   assign hit_head = (paddr == OFF_RX_HEAD) |
                     (paddr == OFF_RX_HEAD_ALIAS);
   assign hit_tail = (paddr == OFF_RX_TAIL) |
                     (paddr == OFF_RX_TAIL_ALIAS);
   assign hit_any = hit_opt | hit_head | hit_tail;
   assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

   // ----------------------------------------------------------------
   // PHY option register
   // ----------------------------------------------------------------
   logic [OPT_W-1:0] opt_q;
   logic [OPT_W-1:0] opt_d;
   logic [OPT_W-1:0] opt_wmask;
   logic [OPT_W-1:0] opt_merged;
   logic wr_opt;
   logic reneg_wr;

   assign wr_opt = wr_fire & hit_opt;
   assign opt_wmask = lane_mask[OPT_W-1:0];
   assign opt_merged = (opt_q & ~opt_wmask) |
                       (pwdata[OPT_W-1:0] & opt_wmask);
   // The restart bit is a command: it fires once and reads back as zero.
   assign reneg_wr = wr_opt & opt_wmask[BIT_REAUTONEG] &
                     pwdata[BIT_REAUTONEG];

   always_comb begin
      opt_d = opt_q;
      if (wr_opt) begin
         opt_d = opt_merged;
      end else if (nvm_load) begin
         opt_d[NVM_LOAD_W-1:0] =
            nvm_word[NVM_FIELD_LSB+NVM_LOAD_W-1:NVM_FIELD_LSB];
      end
      opt_d[BIT_REAUTONEG] = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt_q <= OPT_RESET;
      end else begin
         opt_q <= opt_d;
      end
   end

   // ----------------------------------------------------------------
   // PHY and flash control outputs
   // ----------------------------------------------------------------
   logic slow_d;
   logic gig_off_d;

   // The always-slow bit wins whatever the power state.
   assign slow_d = opt_q[BIT_SLOW_ALWAYS] |
                   (opt_q[BIT_SLOW_LOW_POWER] & ~fully_active_state);
   assign gig_off_d = opt_q[BIT_GIG_DISABLE_ALL] |
                      (opt_q[BIT_GIG_BLOCK_LOW_POWER] &
                       ~fully_active_state);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phy_slow_link <= 1'b0;
         phy_gig_disable <= 1'b0;
         phy_restart_an <= 1'b0;
         phy_line_driver_class <= 1'b0;
         phy_pause_adv <= 1'b0;
         phy_asym_pause_adv <= 1'b0;
         flash_update_req <= 1'b0;
      end else begin
         phy_slow_link <= slow_d;
         phy_gig_disable <= gig_off_d;
         phy_restart_an <= reneg_wr;
         phy_line_driver_class <= opt_q[BIT_LINE_DRIVER_CLASS];
         phy_pause_adv <= opt_q[BIT_PAUSE];
         phy_asym_pause_adv <= opt_q[BIT_ASYM_PAUSE];
         flash_update_req <= flash_read_control_wr &
                             ~opt_q[BIT_FLASH_UPD_BLOCK];
      end
   end

   // ----------------------------------------------------------------
   // Receive pointers
   // ----------------------------------------------------------------
   // Both pointers are word offsets from the start of the whole packet
   // buffer memory, so they are stored and shown unmodified.
   pob_ptr u_rx_head (
      .clk(pclk),
      .rst_n(presetn),
      .adv(rx_head_advance),
      .wr_en(wr_fire & hit_head),
      .wr_data(pwdata[PTR_W-1:0]),
      .wr_mask(lane_mask[PTR_W-1:0]),
      .ptr_q(rx_head_pointer)
   );

   pob_ptr u_rx_tail (
      .clk(pclk),
      .rst_n(presetn),
      .adv(rx_tail_advance),
      .wr_en(wr_fire & hit_tail),
      .wr_data(pwdata[PTR_W-1:0]),
      .wr_mask(lane_mask[PTR_W-1:0]),
      .ptr_q(rx_tail_pointer)
   );

   // ----------------------------------------------------------------
   // Read path and APB answer
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] rd_mux;

   // Upper pointer bits and option bits above bit 9 read as zero; spare option bit 0 reads as stored.
   assign rd_mux =
      hit_opt ? {{(DATA_W-OPT_W){1'b0}}, opt_q} :
      hit_head ? {{(DATA_W-PTR_W){1'b0}}, rx_head_pointer} :
      hit_tail ? {{(DATA_W-PTR_W){1'b0}}, rx_tail_pointer} :
      {DATA_W{1'b0}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= acc_first;
         pslverr <= acc_first & ~hit_any;
         if (acc_first & ~pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_slow_always: assert property (
      @(posedge pclk) disable iff (!presetn)
      opt_q[BIT_SLOW_ALWAYS] |=> phy_slow_link)
      else $error("Slow link not forced by always-slow bit.");

   // The sampled reset term keeps the release edge, where the outputs
   // are still held in reset, from starting an attempt.
   a_slow_low_power: assert property (
      @(posedge pclk) disable iff (!presetn)
      presetn && !opt_q[BIT_SLOW_ALWAYS] |=>
      phy_slow_link == ($past(opt_q[BIT_SLOW_LOW_POWER]) &&
                        !$past(fully_active_state)))
      else $error("Low-power slow link wrong for power state.");

   a_gig_low_power: assert property (
      @(posedge pclk) disable iff (!presetn)
      presetn && opt_q[BIT_GIG_BLOCK_LOW_POWER] && !fully_active_state
      |=> phy_gig_disable)
      else $error("Gigabit not blocked outside fully active.");

   a_gig_all: assert property (
      @(posedge pclk) disable iff (!presetn)
      opt_q[BIT_GIG_DISABLE_ALL] |=> phy_gig_disable)
      else $error("Gigabit not blocked in every state.");

   a_reneg_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      reneg_wr |=> phy_restart_an ##1 !phy_restart_an)
      else $error("Restart pulse missing or too long.");

   a_flash_block: assert property (
      @(posedge pclk) disable iff (!presetn)
      flash_read_control_wr |=>
      flash_update_req == !$past(opt_q[BIT_FLASH_UPD_BLOCK]))
      else $error("Flash update request disagrees with block bit.");

   a_pause_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(opt_q[BIT_PAUSE]) |=> phy_pause_adv == $past(opt_q[BIT_PAUSE]))
      else $error("Pause advertisement does not follow its bit.");

   a_asym_follow: assert property (
      @(posedge pclk) disable iff (!presetn)
      $changed(opt_q[BIT_ASYM_PAUSE]) |=>
      phy_asym_pause_adv == $past(opt_q[BIT_ASYM_PAUSE]))
      else $error("Asymmetric pause does not follow its bit.");

   a_nvm_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      nvm_load && !wr_opt |=>
      opt_q[7:0] == ($past(nvm_word[15:8]) & 8'hDF))
      else $error("Option low byte not loaded from NVM word.");

   a_head_alias: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_first && !pwrite && paddr == OFF_RX_HEAD_ALIAS |=>
      prdata == {19'h0_0000, $past(rx_head_pointer)})
      else $error("Head alias read did not return head pointer.");

   a_tail_alias: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_first && !pwrite && paddr == OFF_RX_TAIL_ALIAS |=>
      prdata == {19'h0_0000, $past(rx_tail_pointer)})
      else $error("Tail alias read did not return tail pointer.");

   a_ptr_upper_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_first && !pwrite && (hit_head || hit_tail) |=>
      prdata[31:13] == 19'h0_0000)
      else $error("Pointer upper bits not zero.");

   a_unmapped_err: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc_first && !hit_any |=> pready && pslverr)
      else $error("Unmapped access not answered with error.");

   c_reneg: cover property (
      @(posedge pclk) disable iff (!presetn) phy_restart_an);
   c_nvm_load: cover property (
      @(posedge pclk) disable iff (!presetn) nvm_load && !wr_opt);
   c_head_alias_rd: cover property (
      @(posedge pclk) disable iff (!presetn)
      acc_done && !pwrite && paddr == OFF_RX_HEAD_ALIAS);
   c_tail_write: cover property (
      @(posedge pclk) disable iff (!presetn) wr_fire && hit_tail);

endmodule
`default_nettype wire

// >>> bench/pob_tb.sv
// Self-checking bench for the PHY option and receive pointer register bank.
// Assumes pob_pkg and pob_regs are compiled first; drives APB directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pob_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, nvm_load, fa, flash_wr;
   logic [15:0] paddr, nvm_word;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic pready, pslverr, flash_req, slow, gig, restart, cls, pause, asym;
   logic head_adv, tail_adv;
   logic [12:0] head_ptr, tail_ptr;
   int n_fail = 0, checks_done = 0, n_rst = 0, n_fl = 0, r0, i;
   typedef struct packed {
      logic [15:0] wa; logic [31:0] wd; logic [15:0] ra; logic [31:0] rx;
      logic re;
   } pob_row_t;
   typedef struct packed {logic [9:0] opt; logic fa; logic [4:0] x;} pob_phy_t;
   pob_row_t rows [6] = '{
      '{OFF_PHY_OPT, 32'hFFFFFFDF, OFF_PHY_OPT, 32'h000003DF, 1'b0},
      '{OFF_RX_HEAD, 32'hFFFFFFFF, OFF_RX_HEAD, 32'h00001FFF, 1'b0},
      '{OFF_RX_HEAD_ALIAS, 32'h00000123, OFF_RX_HEAD, 32'h00000123, 1'b0},
      '{OFF_RX_TAIL, 32'hFFFF2345, OFF_RX_TAIL_ALIAS, 32'h00000345, 1'b0},
      '{16'h0F14, 32'h00000001, 16'h0F14, 32'h00000000, 1'b1},
      '{16'h2412, 32'h00000000, 16'h2412, 32'h00000000, 1'b1}};
   pob_phy_t phy [10] = '{'{10'h000, 1'b1, 5'h00}, '{10'h004, 1'b1, 5'h00},
      '{10'h004, 1'b0, 5'h10}, '{10'h002, 1'b1, 5'h10},
      '{10'h008, 1'b1, 5'h00}, '{10'h008, 1'b0, 5'h08},
      '{10'h040, 1'b1, 5'h08}, '{10'h010, 1'b1, 5'h04},
      '{10'h100, 1'b1, 5'h02}, '{10'h200, 1'b1, 5'h01}};

   pob_regs u_pob_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .nvm_load(nvm_load), .nvm_word(nvm_word), .fully_active_state(fa),
      .flash_read_control_wr(flash_wr), .flash_update_req(flash_req),
      .phy_slow_link(slow), .phy_gig_disable(gig), .phy_restart_an(restart),
      .phy_line_driver_class(cls), .phy_pause_adv(pause),
      .phy_asym_pause_adv(asym), .rx_head_advance(head_adv),
      .rx_tail_advance(tail_adv), .rx_head_pointer(head_ptr),
      .rx_tail_pointer(tail_ptr));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Pulse counters let a scenario check one-cycle outputs by their count.
   always @(posedge pclk) begin
      if (restart === 1'b1) n_rst++;
      if (flash_req === 1'b1) n_fl++;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One APB transfer; the request stands until pready is sampled high.
   task automatic apb(input logic w, input logic [15:0] a,
         input logic [31:0] d, input logic [3:0] s,
         output logic [31:0] rd, output logic er);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w;
      paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         end_sim();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0; penable <= 1'b0;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] s);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, s, r, e);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [31:0] x,
         input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, 4'hF, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic do_reset();
      @(posedge pclk);
      presetn <= 1'b0;
      fa <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdc(OFF_PHY_OPT, 32'h30D, 1'b0);
      rdc(OFF_RX_HEAD, 32'h0, 1'b0);
      rdc(OFF_RX_TAIL, 32'h0, 1'b0);
      chk({27'h0, slow, gig, cls, pause, asym}, 32'h1B);
      $display("reset test done");
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 16'h0; pwdata = 32'h0; pstrb = 4'h0; nvm_load = 1'b0;
      nvm_word = 16'h0; fa = 1'b0; flash_wr = 1'b0;
      head_adv = 1'b0; tail_adv = 1'b0;
      do_reset();
      for (i = 0; i < 6; i++) begin
         wr(rows[i].wa, rows[i].wd, 4'hF);
         rdc(rows[i].ra, rows[i].rx, rows[i].re);
      end
      $display("register table test done");
      for (i = 0; i < 10; i++) begin
         wr(OFF_PHY_OPT, {22'h0, phy[i].opt}, 4'h3);
         fa <= phy[i].fa;
         repeat (3) @(posedge pclk);
         chk({27'h0, slow, gig, cls, pause, asym},
            {27'h0, phy[i].x});
      end
      $display("phy control test done");
      wr(OFF_PHY_OPT, 32'h004, 4'h3);
      repeat (RENEG_SETTLE_CYC) @(posedge pclk);
      r0 = n_rst;
      wr(OFF_PHY_OPT, 32'h024, 4'h1);
      repeat (3) @(posedge pclk);
      chk(32'(n_rst - r0), 32'h1);
      wr(OFF_PHY_OPT, 32'h020, 4'h2);
      repeat (3) @(posedge pclk);
      chk(32'(n_rst - r0), 32'h1);
      rdc(OFF_PHY_OPT, 32'h004, 1'b0);
      $display("restart test done");
      for (i = 0; i < 2; i++) begin
         wr(OFF_PHY_OPT, (i == 0) ? 32'h000 : 32'h080, 4'h3);
         r0 = n_fl;
         @(posedge pclk);
         flash_wr <= 1'b1;
         @(posedge pclk);
         flash_wr <= 1'b0;
         repeat (3) @(posedge pclk);
         chk(32'(n_fl - r0), (i == 0) ? 32'h1 : 32'h0);
      end
      $display("flash test done");
      wr(OFF_PHY_OPT, 32'h000, 4'h3);
      r0 = n_rst;
      @(posedge pclk);
      nvm_word <= 16'hFF00;
      nvm_load <= 1'b1;
      @(posedge pclk);
      nvm_load <= 1'b0;
      rdc(OFF_PHY_OPT, 32'h0DF, 1'b0);
      chk(32'(n_rst - r0), 32'h0);
      $display("nvm load test done");
      wr(OFF_RX_HEAD, 32'h1FFE, 4'h3);
      wr(OFF_RX_TAIL_ALIAS, 32'h0010, 4'h3);
      @(posedge pclk);
      head_adv <= 1'b1;
      tail_adv <= 1'b1;
      repeat (2) @(posedge pclk);
      tail_adv <= 1'b0;
      @(posedge pclk);
      head_adv <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({19'h0, head_ptr}, 32'h1);
      rdc(OFF_RX_HEAD_ALIAS, 32'h1, 1'b0);
      rdc(OFF_RX_TAIL, 32'h12, 1'b0);
      chk({19'h0, tail_ptr}, 32'h12);
      $display("pointer test done");
      do_reset();
      end_sim();
   end
endmodule
`default_nettype wire
